// *** src/fpsl_pkg.sv ***
// Package for the flash protection and status logic.
// Assumes a byte-wide register port with one-cycle read latency.
package fpsl_pkg;
	// Register offsets (word index on the plain port)
	localparam logic [3:0] OFS_STATUS   = 4'h0;
	localparam logic [3:0] OFS_PROT     = 4'h1;
	localparam logic [3:0] OFS_CONFIG   = 4'h2;
	localparam logic [3:0] OFS_SEQ      = 4'h3;
	localparam logic [3:0] OFS_PROBE    = 4'h4;
	// Status bit positions
	localparam int BIT_BEMPTY  = 7;
	localparam int BIT_DONE    = 6;
	localparam int BIT_PROTECT_VIOLATION_FLAG   = 5;
	localparam int BIT_ACCESS_ERROR_FLAG  = 4;
	localparam int BIT_BLANK   = 2;
	localparam int BIT_FAIL    = 1;
	// Protection register fields
	localparam int BIT_OPEN    = 7;
	localparam int BIT_RSV     = 6;
	localparam int BIT_HDIS    = 5;
	localparam int BIT_HS_LO   = 3;
	localparam int BIT_LDIS    = 2;
	localparam int BIT_LS_LO   = 0;
	// Config register bits
	localparam int BIT_BEIE    = 7;
	localparam int BIT_DONEIE  = 6;
	localparam int BIT_SPECIAL = 0;
	// Sequence control register bits (software model of command controller)
	localparam int BIT_WORDWR  = 0;
	localparam int BIT_BADCMD  = 1;
	localparam int BIT_ABORTER = 2;
	localparam int BIT_STOP    = 3;
	localparam int BIT_EVERIFY = 4;
	localparam int BIT_BLANKIN = 5;
	localparam int BIT_FINISH  = 6;
	localparam int BIT_MASSERS = 7;
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_PROT   = 8'hFF;
	// Address windows
	localparam logic [15:0] HI_TOP     = 16'hFFFF;
	localparam logic [15:0] LO_BASE    = 16'h4000;
	localparam logic [15:0] PG_HI_TOP  = 16'hCFFF;
	localparam logic [15:0] PG_LO_BASE = 16'h8000;
	localparam logic [7:0]  PG_HI_A    = 8'h37;
	localparam logic [7:0]  PG_HI_B    = 8'h3F;
	localparam logic [7:0]  PG_LO_A    = 8'h36;
	localparam logic [7:0]  PG_LO_B    = 8'h3E;
	localparam logic [15:0] HI_SIZE_BASE = 16'h0800;
	localparam logic [15:0] LO_SIZE_BASE = 16'h0400;
	// Allowed transition matrix: row = from, bit = to
	localparam logic [7:0] TRANS_OK [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
		8'h18, 8'h3C, 8'h5A, 8'hFF};
endpackage

// *** src/fpsl_range_check.sv ***
// Range decoder: tells whether an address lies in a protected area.
// Assumes a 16-bit CPU address and an 8-bit page register.
module fpsl_range_check (
	// Protection setting
	input  wire logic [7:0]  protCfg,
	// Target address
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  page,
	input  wire logic        paged,
	// Result
	output logic             isProt
);
	logic [15:0] hiSize;     // Upper range size in bytes
	logic [15:0] loSize;     // Lower range size in bytes
	logic        inHi;       // Address inside upper range
	logic        inLo;       // Address inside lower range
	logic        hiOn;       // Upper range in use
	logic        loOn;       // Lower range in use

	// Decode sizes and range membership
	always_comb begin
		hiSize = fpsl_pkg::HI_SIZE_BASE << protCfg[fpsl_pkg::BIT_HS_LO +: 2];
		loSize = fpsl_pkg::LO_SIZE_BASE << protCfg[fpsl_pkg::BIT_LS_LO +: 2];
		hiOn = !protCfg[fpsl_pkg::BIT_HDIS];
		loOn = !protCfg[fpsl_pkg::BIT_LDIS];
		if (paged) begin
			// Mirrored windows in the upper and lower pages
			inHi = ((page == fpsl_pkg::PG_HI_A) || (page == fpsl_pkg::PG_HI_B)) &&
				(addr <= fpsl_pkg::PG_HI_TOP) &&
				(addr > 16'(fpsl_pkg::PG_HI_TOP - hiSize));
			inLo = ((page == fpsl_pkg::PG_LO_A) || (page == fpsl_pkg::PG_LO_B)) &&
				(addr >= fpsl_pkg::PG_LO_BASE) &&
				(addr < 16'(fpsl_pkg::PG_LO_BASE + loSize));
		end else begin
			inHi = addr > 16'(fpsl_pkg::HI_TOP - hiSize);
			inLo = (addr >= fpsl_pkg::LO_BASE) &&
				(addr < 16'(fpsl_pkg::LO_BASE + loSize));
		end
		// Open mode protects only the enabled ranges; otherwise all but the enabled ranges
		if (protCfg[fpsl_pkg::BIT_OPEN])
			isProt = (hiOn && inHi) || (loOn && inLo);
		else
			isProt = !((hiOn && inHi) || (loOn && inLo));
	end
endmodule

// *** src/fpsl_top.sv ***
// Flash protection and status logic: protection register, status flags.
// Assumes a plain register port, straps from the nonvolatile field valid
// at reset release, and a command controller reporting events as pulses.
//
// Operation
// - Upper range sizes 2/4/8/16 KB, mirrored paged
// - Lower range sizes 1/2/4/8 KB, mirrored paged
// - Load protection at reset, software may change
// - Protection changes only toward more protection
// - Disallowed scenario writes leave register unchanged
// - Protection register reads active scenario
// - Write one clears buffer-empty flag
// - Zero write mid-sequence aborts, sets access error
// - Buffer-empty and enable raise interrupt
// - Done clears with buffer-empty, sets when idle
// - Done ignores writes, interrupt with enable
// - Protected program/erase sets violation, one clears
// - Violation blocks launch and new sequences
// - Access error on sequence, command, abort, stop
// - Access error write-one clear, blocks all banks
// - Verify/compress error discards buffered command
// - Blank reports verify result, cleared on new sequence
// - Fail set by verify, clear-one, special mode only
// - Unused status bits read zero
// - Size writes only when range disabled; open mode
// - Mass erase refused when any sector protected
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
module fpsl_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [7:0]  regRdData,
	// Nonvolatile protection byte, sampled after reset
	input  wire logic [7:0]  nvProtByte,
	// Command controller events, same clock
	input  wire logic        arrayWordWr,
	input  wire logic [15:0] arrayAddr,
	input  wire logic [7:0]  arrayPage,
	input  wire logic        arrayPaged,
	input  wire logic        cmdIsMassErase,
	input  wire logic        cmdIsVerify,
	input  wire logic        cmdIsCompress,
	input  wire logic        illegalCmd,
	input  wire logic        eraseAbortEarly,
	input  wire logic        stopReq,
	input  wire logic        allCmdsDone,
	input  wire logic        verifyDone,
	input  wire logic        verifyBlank,
	input  wire logic        otherBankAccErr,
	// Outputs to controller and interrupt logic
	output logic             launchCmd,
	output logic             discardBuffered,
	output logic             seqAllowed,
	output logic             accErrOut,
	output logic             bufEmptyIrq,
	output logic             doneIrq
);
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,   // No sequence in progress
		SEQ_WORD = 3'b010,   // Array word written, awaiting launch
		SEQ_RUN  = 3'b100    // Commands executing
	} fpsl_seq_t;

	fpsl_seq_t   seq_r;          // Sequence state
	fpsl_seq_t   seq_nxt;        // Next sequence state
	logic [7:0]  prot_r;         // Active protection setting
	logic [7:0]  cfg_r;          // Interrupt enables and mode
	logic [7:0]  seqCtl_r;       // Software event register
	logic        bEmpty_r;       // Buffer-empty flag
	logic        done_r;         // All-done flag
	logic        protect_violation_flag_r;        // Protection violation flag
	logic        access_error_flag_r;       // Access error flag
	logic        blank_r;        // Erase verify result
	logic        fail_r;         // Failure flag
	logic        loaded_r;       // Reset load performed
	logic        isProt;         // Target in protected area
	logic        massBlocked;    // Some sector protected
	logic [7:0]  wrProt;         // Candidate protection value
	logic        statWr;         // Status register write
	logic        launchReq;      // Launch by clearing buffer-empty
	logic        abortZero;      // Zero write mid-sequence
	logic        evWordWr;       // Word write event
	logic        evBadCmd;       // Illegal command event
	logic        evAbort;        // Early abort event
	logic        evStop;         // Stop event
	logic        evVerify;       // Verify finished event
	logic        evBlankIn;      // Verify result
	logic        evDone;         // All commands finished
	logic        evMass;         // Mass erase requested
	logic        accSet;         // Access error set term
	logic        pvSet;          // Violation set term
	logic        blocked;        // Errors pending anywhere

	// Scenario index from open and disable bits
	function automatic logic [2:0] scen(input logic [7:0] p);
		scen = {p[fpsl_pkg::BIT_OPEN], p[fpsl_pkg::BIT_HDIS],
			p[fpsl_pkg::BIT_LDIS]};
	endfunction

	// Write-one-clear helper with set priority
	function automatic logic w1c(input logic cur, input logic set, input logic clr);
		w1c = set ? 1'b1 : (clr ? 1'b0 : cur);
	endfunction

	// Protection decode for the current target
	fpsl_range_check uRange (
		.protCfg (prot_r),
		.addr    (arrayAddr),
		.page    (arrayPage),
		.paged   (arrayPaged),
		.isProt  (isProt)
	);

	// Any protected sector means mass erase refused
	assign massBlocked = !(prot_r[fpsl_pkg::BIT_OPEN] &&
		prot_r[fpsl_pkg::BIT_HDIS] && prot_r[fpsl_pkg::BIT_LDIS]);

	// Combine controller pins with software event register
	assign evWordWr  = arrayWordWr || seqCtl_r[fpsl_pkg::BIT_WORDWR];
	assign evBadCmd  = illegalCmd || seqCtl_r[fpsl_pkg::BIT_BADCMD];
	assign evAbort   = eraseAbortEarly || seqCtl_r[fpsl_pkg::BIT_ABORTER];
	assign evStop    = stopReq || seqCtl_r[fpsl_pkg::BIT_STOP];
	assign evVerify  = verifyDone || seqCtl_r[fpsl_pkg::BIT_EVERIFY];
	assign evBlankIn = verifyBlank || seqCtl_r[fpsl_pkg::BIT_BLANKIN];
	assign evDone    = allCmdsDone || seqCtl_r[fpsl_pkg::BIT_FINISH];
	assign evMass    = cmdIsMassErase || seqCtl_r[fpsl_pkg::BIT_MASSERS];

	// Decode status writes
	assign statWr    = regWrStb && (regAddr == fpsl_pkg::OFS_STATUS);
	assign blocked   = protect_violation_flag_r || access_error_flag_r || otherBankAccErr;
	assign abortZero = statWr && (seq_r == SEQ_WORD) &&
		!regWrData[fpsl_pkg::BIT_BEMPTY];
	assign launchReq = statWr && regWrData[fpsl_pkg::BIT_BEMPTY] && bEmpty_r &&
		(seq_r == SEQ_WORD) && !blocked && !pvSet;
	assign pvSet     = evWordWr && (seq_r != SEQ_RUN) && !blocked &&
		(isProt || (evMass && massBlocked));
	assign accSet    = abortZero || evBadCmd || evAbort ||
		(evStop && !done_r);

	// Sequence state transitions
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SEQ_IDLE: if (evWordWr && bEmpty_r && !blocked) seq_nxt = SEQ_WORD;
			SEQ_WORD: if (abortZero || pvSet || accSet) seq_nxt = SEQ_IDLE;
				else if (launchReq) seq_nxt = SEQ_RUN;
			SEQ_RUN:  if (evDone) seq_nxt = SEQ_IDLE;
			default:  seq_nxt = SEQ_IDLE;
		endcase
	end

	// Sequence state register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) seq_r <= SEQ_IDLE;
		else seq_r <= seq_nxt;
	end

	// Candidate protection value: size fields only writable when range off
	always_comb begin
		wrProt = regWrData;
		wrProt[fpsl_pkg::BIT_RSV] = prot_r[fpsl_pkg::BIT_RSV];
		if (!prot_r[fpsl_pkg::BIT_HDIS])
			wrProt[fpsl_pkg::BIT_HS_LO +: 2] = prot_r[fpsl_pkg::BIT_HS_LO +: 2];
		if (!prot_r[fpsl_pkg::BIT_LDIS])
			wrProt[fpsl_pkg::BIT_LS_LO +: 2] = prot_r[fpsl_pkg::BIT_LS_LO +: 2];
	end

	// Protection register: nonvolatile load once, then restricted writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prot_r   <= fpsl_pkg::RST_PROT;
			loaded_r <= 1'b0;
		end else if (!loaded_r) begin
			prot_r   <= nvProtByte;
			loaded_r <= 1'b1;
		end else if (regWrStb && (regAddr == fpsl_pkg::OFS_PROT) &&
			fpsl_pkg::TRANS_OK[scen(prot_r)][scen(wrProt)]) begin
			prot_r <= wrProt;
		end
	end

	// Config register: interrupt enables and special mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) cfg_r <= fpsl_pkg::RST_CONFIG;
		else if (regWrStb && (regAddr == fpsl_pkg::OFS_CONFIG)) cfg_r <= regWrData;
	end

	// Software event register: pulses for one cycle per write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) seqCtl_r <= 8'h00;
		else if (regWrStb && (regAddr == fpsl_pkg::OFS_SEQ)) seqCtl_r <= regWrData;
		else seqCtl_r <= 8'h00;
	end

	// Buffer-empty flag: clears on launch, sets when buffer drains
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) bEmpty_r <= 1'b1;
		else if (launchReq) bEmpty_r <= 1'b0;
		else if (seq_r == SEQ_RUN) bEmpty_r <= 1'b1;
	end

	// Done flag: low while buffer-empty low, high when all finished
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) done_r <= 1'b1;
		else if (launchReq || !bEmpty_r) done_r <= 1'b0;
		else if ((seq_r == SEQ_RUN) && evDone) done_r <= 1'b1;
	end

	// Violation flag, set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) protect_violation_flag_r <= 1'b0;
		else protect_violation_flag_r <= w1c(protect_violation_flag_r, pvSet,
			statWr && regWrData[fpsl_pkg::BIT_PROTECT_VIOLATION_FLAG]);
	end

	// Access error flag, set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) access_error_flag_r <= 1'b0;
		else access_error_flag_r <= w1c(access_error_flag_r, accSet,
			statWr && regWrData[fpsl_pkg::BIT_ACCESS_ERROR_FLAG]);
	end

	// Blank and fail flags from verify result
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			blank_r <= 1'b0;
			fail_r  <= 1'b0;
		end else begin
			if (launchReq) blank_r <= 1'b0;
			else if (evVerify) blank_r <= evBlankIn;
			fail_r <= w1c(fail_r, evVerify && !evBlankIn,
				statWr && cfg_r[fpsl_pkg::BIT_SPECIAL] &&
				regWrData[fpsl_pkg::BIT_FAIL]);
		end
	end

	// Controller handshake outputs and interrupt requests
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			launchCmd       <= 1'b0;
			discardBuffered <= 1'b0;
			seqAllowed      <= 1'b0;
			accErrOut       <= 1'b0;
			bufEmptyIrq     <= 1'b0;
			doneIrq         <= 1'b0;
		end else begin
			launchCmd       <= launchReq;
			discardBuffered <= accSet && (cmdIsVerify || cmdIsCompress);
			seqAllowed      <= !blocked && bEmpty_r && !fail_r;
			accErrOut       <= access_error_flag_r;
			bufEmptyIrq     <= bEmpty_r && cfg_r[fpsl_pkg::BIT_BEIE];
			doneIrq         <= done_r && cfg_r[fpsl_pkg::BIT_DONEIE];
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) regRdData <= 8'h00;
		else if (regRdStb) begin
			case (regAddr)
				fpsl_pkg::OFS_STATUS: regRdData <= {bEmpty_r, done_r, protect_violation_flag_r,
					access_error_flag_r, 1'b0, blank_r, fail_r, 1'b0};
				fpsl_pkg::OFS_PROT:   regRdData <= prot_r;
				fpsl_pkg::OFS_CONFIG: regRdData <= cfg_r;
				fpsl_pkg::OFS_PROBE:  regRdData <= {5'h00, seq_r};
				default:              regRdData <= 8'h00;
			endcase
		end else regRdData <= 8'h00;
	end
endmodule

// *** verification/fpsl_cpu_model.sv ***
// CPU model: byte accesses on the plain register port.
// Assumes the slave answers a read in the cycle after its strobe.
module fpsl_cpu_model (
	// Clock
	input  wire logic       sys_clk,
	// Register port
	output logic      [3:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrStb,
	output logic            regRdStb,
	input  wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end
	// One-cycle write; data inverted on release so stale bytes never match
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
		regWrData <= ~v;
	endtask
	// One-cycle read; data taken in the following cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		v = regRdData;
	endtask
endmodule

// *** verification/fpsl_chk_sva.sv ***
// Checker: timing relations on the protection and status ports.
// Assumes it is bound into fpsl_top and sees only its ports.
module fpsl_chk (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrStb,
	input wire logic       regRdStb,
	input wire logic [7:0] regRdData,
	// Events and results
	input wire logic       illegalCmd,
	input wire logic       eraseAbortEarly,
	input wire logic       otherBankAccErr,
	input wire logic       launchCmd,
	input wire logic       seqAllowed,
	input wire logic       accErrOut,
	input wire logic       bufEmptyIrq,
	input wire logic       doneIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [1:0] cfgIe_r; // Shadow of the two interrupt enables
	// Follow writes to the config register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) cfgIe_r <= 2'b00;
		else if (regWrStb && regAddr == fpsl_pkg::OFS_CONFIG) cfgIe_r <= regWrData[7:6];
	end
	AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
		else $error("read data not zero outside read slot");
	AST_RD_UNUSED: assert property ($past(regRdStb) && $past(regAddr) == fpsl_pkg::OFS_STATUS
		|-> regRdData[3] == 1'b0 && regRdData[0] == 1'b0)
		else $error("unused status bit reads one");
	AST_LAUNCH_CAUSE: assert property (launchCmd
		|-> $past(regWrStb && regAddr == fpsl_pkg::OFS_STATUS && regWrData[7]))
		else $error("launch without a buffer-empty clear");
	AST_LAUNCH_OK: assert property (launchCmd |-> !accErrOut)
		else $error("launch while access error pending");
	AST_ACC_BLOCK: assert property (accErrOut && $past(accErrOut) |-> !seqAllowed)
		else $error("sequence allowed during access error");
	AST_OTHER_BANK: assert property (otherBankAccErr [*2] |-> !seqAllowed)
		else $error("sequence allowed during other bank error");
	AST_ILLEGAL: assert property (illegalCmd |-> ##[1:2] accErrOut)
		else $error("illegal command left no access error");
	AST_ABORT: assert property (eraseAbortEarly |-> ##[1:2] accErrOut)
		else $error("early erase abort left no access error");
	AST_BE_IRQ: assert property (!$past(cfgIe_r[1]) && !$past(cfgIe_r[1], 2)
		|-> !bufEmptyIrq)
		else $error("buffer interrupt while disabled");
	AST_DONE_IRQ: assert property (!$past(cfgIe_r[0]) && !$past(cfgIe_r[0], 2)
		|-> !doneIrq)
		else $error("completion interrupt while disabled");
endmodule
bind fpsl_top fpsl_chk u_chk (.sys_clk, .rst_n, .regAddr, .regWrData, .regWrStb,
	.regRdStb, .regRdData, .illegalCmd, .eraseAbortEarly, .otherBankAccErr, .launchCmd,
	.seqAllowed, .accErrOut, .bufEmptyIrq, .doneIrq);

// *** verification/flash_protect_status_logic_bench.sv ***
// Testbench for the flash protection and status logic.
// Assumes fpsl_top, its checker and the CPU model are compiled first.
module flash_protect_status_logic_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] ST = fpsl_pkg::OFS_STATUS; // Status index
	localparam logic [3:0] PR = fpsl_pkg::OFS_PROT;   // Protection index
	localparam logic [3:0] CF = fpsl_pkg::OFS_CONFIG; // Config index
	logic        sys_clk, rst_n;              // Clock and reset
	logic [3:0]  regAddr;                     // Register port, from the CPU model
	logic [7:0]  regWrData, regRdData;
	logic        regWrStb, regRdStb;
	logic [7:0]  nvProtByte;                  // Nonvolatile protection byte
	logic        arrayWordWr, arrayPaged;     // Array word write target
	logic [15:0] arrayAddr, hi, lo;
	logic [7:0]  arrayPage, fb, tb, d;
	logic        vfy, verifyBlank;            // Verify command and outcome
	logic [4:0]  ev;                          // Illegal, abort, stop, done, verify
	logic        otherBankAccErr;             // Error pending elsewhere
	logic        mass, dsc;                   // Mass erase command, discard pulse
	logic        launchCmd, seqAllowed, accErrOut, bufEmptyIrq, doneIrq;
	int          miscompares, nChecks, nLaunch, n;
	fpsl_cpu_model cpu (.sys_clk, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData);
	fpsl_top uut (.sys_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
		.nvProtByte, .arrayWordWr, .arrayAddr, .arrayPage, .arrayPaged, .cmdIsMassErase(mass),
		.cmdIsVerify(vfy), .cmdIsCompress(1'b0), .illegalCmd(ev[0]), .eraseAbortEarly(ev[1]),
		.stopReq(ev[2]), .allCmdsDone(ev[3]), .verifyDone(ev[4]), .verifyBlank,
		.otherBankAccErr, .launchCmd, .discardBuffered(dsc), .seqAllowed, .accErrOut,
		.bufEmptyIrq, .doneIrq);
	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Count launch pulses
	always @(posedge sys_clk) if (launchCmd === 1'b1) nLaunch++;
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		nChecks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic rdChk(input string nm, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		cpu.rd(a, v);
		chk(nm, e, v);
	endtask
	// Reset held 20 cycles with the given strap
	task automatic doReset(input logic [7:0] nv);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		nvProtByte <= nv;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic ww(input logic [15:0] a, input logic [7:0] p, input logic pg);
		@(posedge sys_clk);
		{arrayAddr, arrayPage, arrayPaged, arrayWordWr} <= {a, p, pg, 1'b1};
		@(posedge sys_clk);
		arrayWordWr <= 1'b0;
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'b1;
		@(posedge sys_clk);
		ev <= 5'h00;
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// Word write then buffer-empty clear, on an open address
	task automatic seq();
		ww(16'h7000, 8'h00, 1'b0);
		cpu.wr(ST, 8'h80);
	endtask
	// Word write at a target, check the violation flag against e, then clean up
	task automatic probe(input logic [15:0] a, input logic [7:0] p, input logic pg, input logic e);
		logic [7:0] v;
		ww(a, p, pg);
		cpu.rd(ST, v);
		chk("protect_violation_flag", {7'h00, e}, {7'h00, v[5]});
		cpu.wr(ST, 8'h00);
		cpu.wr(ST, 8'h30);
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		giveVerdict();
	end
	initial begin
		{rst_n, nvProtByte, arrayWordWr, arrayAddr, arrayPage, arrayPaged} = '0;
		{vfy, verifyBlank, ev, otherBankAccErr, miscompares, nChecks, nLaunch} = '0;
		mass = 1'b0;
		doReset(8'hFF);
		rdChk("status", ST, 8'hC0);
		rdChk("config", CF, 8'h00);
		rdChk("seqstate", fpsl_pkg::OFS_PROBE, 8'h01);
		rdChk("unmapped", 4'hF, 8'h00);
		cpu.wr(ST, 8'h4F);
		rdChk("status", ST, 8'hC0);
		$display("test reset done");
		for (int f = 0; f < 8; f++) begin
			for (int t = 0; t < 8; t++) begin
				fb = {f[2], 1'b1, f[1], 2'b00, f[0], 2'b00};
				tb = {t[2], 1'b1, t[1], 2'b00, t[0], 2'b00};
				doReset(fb);
				rdChk("prot", PR, fb);
				cpu.wr(PR, tb);
				rdChk("prot", PR, fpsl_pkg::TRANS_OK[f][t] ? tb : fb);
			end
		end
		doReset(8'hFF);
		cpu.wr(PR, 8'hC4);
		cpu.wr(PR, 8'hCC);
		rdChk("prot", PR, 8'hC4);
		$display("test transitions done");
		for (int s = 0; s < 4; s++) begin
			hi = 16'h0000 - (16'h0800 << s);
			lo = 16'h4000 + (16'h0400 << s);
			doReset(8'hFF);
			cpu.wr(PR, {3'b110, s[1:0], 3'b100});
			probe(hi, 8'h00, 1'b0, 1'b1);
			probe(hi - 16'h0002, 8'h00, 1'b0, 1'b0);
			probe(16'hCFFE, 8'h3F, 1'b1, 1'b1);
			probe(16'hCFFE, 8'h35, 1'b1, 1'b0);
			if (s < 3) probe(hi - 16'h3002, 8'h37, 1'b1, 1'b0);
			doReset(8'hFF);
			cpu.wr(PR, {6'b111000, s[1:0]});
			probe(lo - 16'h0002, 8'h00, 1'b0, 1'b1);
			probe(lo, 8'h00, 1'b0, 1'b0);
			probe(lo + 16'h3FFE, 8'h3E, 1'b1, 1'b1);
			probe(lo + 16'h4000, 8'h36, 1'b1, 1'b0);
		end
		doReset(8'h44);
		probe(16'hF800, 8'h00, 1'b0, 1'b0);
		probe(16'hF7FE, 8'h00, 1'b0, 1'b1);
		doReset(8'hFF);
		cpu.wr(PR, 8'hC4);
		mass <= 1'b1;
		probe(16'h7000, 8'h00, 1'b0, 1'b1);
		mass <= 1'b0;
		probe(16'h7000, 8'h00, 1'b0, 1'b0);
		$display("test ranges done");
		doReset(8'hFF);
		ww(16'h7000, 8'h00, 1'b0);
		cpu.wr(ST, 8'h00);
		rdChk("status", ST, 8'hD0);
		chk("seqAllowed", 8'h00, {7'h00, seqAllowed});
		cpu.wr(ST, 8'h10);
		rdChk("status", ST, 8'hC0);
		cpu.wr(ST, 8'h00);
		rdChk("status", ST, 8'hC0);
		cpu.wr(CF, 8'hC0);
		settle();
		chk("irqs", 8'h03, {6'h00, bufEmptyIrq, doneIrq});
		n = nLaunch;
		seq();
		settle();
		chk("launch", 8'h01, 8'(nLaunch - n));
		rdChk("status", ST, 8'h80);
		cpu.wr(ST, 8'h40);
		rdChk("status", ST, 8'h80);
		chk("doneIrq", 8'h00, {7'h00, doneIrq});
		pulse(3);
		rdChk("status", ST, 8'hC0);
		chk("doneIrq", 8'h01, {7'h00, doneIrq});
		cpu.wr(CF, 8'h00);
		settle();
		chk("irqs", 8'h00, {6'h00, bufEmptyIrq, doneIrq});
		for (int i = 0; i < 3; i++) begin
			seq();
			pulse(i);
			#1;
			chk("discard", 8'h00, {7'h00, dsc});
			cpu.rd(ST, d);
			chk("access_error_flag", 8'h01, {7'h00, d[4]});
			pulse(3);
			cpu.wr(ST, 8'h10);
		end
		$display("test sequence done");
		vfy <= 1'b1;
		seq();
		pulse(0);
		#1;
		chk("discard", 8'h01, {7'h00, dsc});
		pulse(3);
		cpu.wr(ST, 8'h10);
		seq();
		pulse(4);
		pulse(3);
		rdChk("status", ST, 8'hC2);
		cpu.wr(ST, 8'h02);
		rdChk("status", ST, 8'hC2);
		cpu.wr(CF, 8'h01);
		cpu.wr(ST, 8'h02);
		rdChk("status", ST, 8'hC0);
		verifyBlank <= 1'b1;
		seq();
		pulse(4);
		pulse(3);
		rdChk("status", ST, 8'hC4);
		seq();
		rdChk("status", ST, 8'h80);
		pulse(3);
		$display("test verify done");
		cpu.wr(PR, 8'hC4);
		ww(16'hF800, 8'h00, 1'b0);
		n = nLaunch;
		seq();
		settle();
		chk("launch", 8'h00, 8'(nLaunch - n));
		chk("seqAllowed", 8'h00, {7'h00, seqAllowed});
		otherBankAccErr <= 1'b1;
		settle();
		chk("seqAllowed", 8'h00, {7'h00, seqAllowed});
		otherBankAccErr <= 1'b0;
		$display("test blocking done");
		giveVerdict();
	end
endmodule
